// ==== common/irq_ctrl_pkg.sv ====
/*
  Constants for the interrupt latch, enable and nesting block: SFR offsets,
  bit positions, source layout, reset values and acceptance timing.
  Assumes an 8-bit SFR bus driven by the CPU core on the system clock.
*/
package irq_ctrl_pkg;

  localparam int unsigned NUM_SRC      = 39;
  localparam int unsigned SRC_W        = 6;
  localparam int unsigned ADDR_W       = 8;

  localparam logic [7:0] OFS_LATCH_TOP      = 8'h2B;
  localparam logic [7:0] OFS_ENABLE_TOP     = 8'h2A;
  localparam logic [7:0] OFS_ENABLE_MID_LO  = 8'h2C;
  localparam logic [7:0] OFS_ENABLE_MID_HI  = 8'h2D;
  localparam logic [7:0] OFS_LATCH_MID_LO   = 8'h2E;
  localparam logic [7:0] OFS_LATCH_MID_HI   = 8'h2F;
  localparam logic [7:0] OFS_ENABLE_LOW     = 8'h3A;
  localparam logic [7:0] OFS_ENABLE_HIGH    = 8'h3B;
  localparam logic [7:0] OFS_LATCH_LOW      = 8'h3C;
  localparam logic [7:0] OFS_LATCH_HIGH     = 8'h3D;

  // Bit positions in the 40-bit latch and enable images (bit n = source n; bit 0 also holds the master enable and nesting level).
  localparam int unsigned MASTER_BIT   = 0;
  localparam int unsigned NEST_LSB     = 0;
  localparam int unsigned WDT_SRC      = 2;
  localparam int unsigned EXT0_SRC     = 3;
  localparam int unsigned FIRST_MASK   = 3;

  // Implemented latch and enable positions; zeros have no latch or enable flag of their own.
  localparam logic [39:0] LATCH_IMPL   = 40'h7F_FFFF_BF6C;
  localparam logic [39:0] ENABLE_IMPL  = 40'h7F_FFFF_BF68;

  localparam logic [39:0] LATCH_RESET  = 40'h00_0000_0000;
  localparam logic [39:0] ENABLE_RESET = 40'h00_0000_0000;
  localparam logic [1:0]  NEST_RESET   = 2'h0;

  localparam logic [1:0]  NEST_CMD_CLEAR = 2'h1;
  localparam logic [1:0]  NEST_CMD_DEC   = 2'h2;

  localparam int unsigned NEST_CNT_W   = 4;
  localparam int unsigned ACCEPT_CYCLES = 12;
  localparam int unsigned ACC_CNT_W    = 4;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACCEPT = 3'b010,
    ST_DONE   = 3'b100
  } accept_state_t;

endpackage

// ==== logic/irq_priority_pick.sv ====
/*
  Fixed priority encoder: lowest source number wins.
  Assumes a one-cycle combinational path is acceptable on the request vector.
*/
`timescale 1ns/100ps
module irq_priority_pick
  import irq_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_SRC
)(
  input  wire logic [WIDTH-1:0]  req_in,
  output logic                   any_out,
  output logic [SRC_W-1:0]       index_out
);

  always_comb
  begin
    any_out   = 1'b0;
    index_out = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        any_out   = 1'b1;
        index_out = SRC_W'(i);
      end
    end
  end

endmodule // irq_priority_pick

// ==== logic/irq_sync2.sv ====
/*
  Two flip-flop synchroniser for a vector of asynchronous levels.
  Assumes the inputs are levels held at least two clocks.
*/
`timescale 1ns/100ps
module irq_sync2
#(
  parameter int unsigned WIDTH = 1
)(
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // irq_sync2

// ==== logic/irq_latch_ctrl.sv ====
/*
  Interrupt request latches, individual and master enables, acceptance
  handshake and nesting counter for an 8-bit CPU core.
  Assumes requests are one-cycle pulses from logic on sys_clk_in, except
  ext_pin_req_in which comes from pins; the core drives the SFR strobes and
  instruction events synchronously.
*/
`timescale 1ns/100ps
module irq_latch_ctrl
  import irq_ctrl_pkg::*;
(
  input  wire logic                sys_clk_in,
  input  wire logic                nrst_in,
  input  wire logic                clk_en_in,
  input  wire logic [NUM_SRC-1:0]  src_req_in,
  input  wire logic [NUM_SRC-1:0]  ext_pin_req_in,
  input  wire logic                sfr_wr_in,
  input  wire logic                sfr_rd_in,
  input  wire logic [ADDR_W-1:0]   sfr_addr_in,
  input  wire logic [7:0]          sfr_wdata_in,
  output logic      [7:0]          sfr_rdata_out,
  output logic                     sfr_hit_out,
  input  wire logic                instr_done_in,
  input  wire logic                swi_in,
  input  wire logic                undef_in,
  input  wire logic                addr_trap_in,
  input  wire logic                unmask_all_instr_in,
  input  wire logic                mask_all_instr_in,
  input  wire logic                maskable_return_instr_in,
  input  wire logic                nonmaskable_return_instr_in,
  input  wire logic                saved_master_in,
  output logic                     irq_pending_out,
  output logic                     accept_start_out,
  output logic                     accept_busy_out,
  output logic                     accept_done_out,
  output logic      [SRC_W-1:0]    accept_src_out,
  output logic                     saved_master_out,
  output logic      [1:0]          nesting_level_field_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisation.

  logic                rst_meta;
  logic                rst_n;
  logic [NUM_SRC-1:0]  ext_sync;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  irq_sync2 #(
    .WIDTH    (NUM_SRC)
  ) u_pin_sync (
    .clk_in   (sys_clk_in),
    .nrst_in  (rst_n),
    .async_in (ext_pin_req_in),
    .sync_out (ext_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [39:0]         request_latch;
  logic [39:0]         source_enable_flag;
  logic                master_enable_flag;
  logic [NEST_CNT_W-1:0] nest_count;
  accept_state_t       state;
  logic [ACC_CNT_W-1:0] acc_count;
  logic [SRC_W-1:0]    acc_src;
  logic                acc_soft;

  logic [39:0]         raise;
  logic [39:0]         sw_clear;
  logic [39:0]         hw_clear;
  logic [39:0]         en_wr_mask;
  logic [39:0]         en_wr_data;
  logic [NUM_SRC-1:0]  eligible;
  logic                pick_any;
  logic [SRC_W-1:0]    pick_idx;
  logic                soft_req;
  logic                start;
  logic [1:0]          nest_cmd;
  logic                nest_wr;

  assign raise = {1'b0, src_req_in | ext_sync} & LATCH_IMPL;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode: byte lanes of the 40-bit latch and enable images.

  always_comb
  begin
    sw_clear   = '0;
    en_wr_mask = '0;
    en_wr_data = '0;
    nest_wr    = 1'b0;
    nest_cmd   = sfr_wdata_in[1:0];
    if (sfr_wr_in)
    begin
      unique case (sfr_addr_in)
        OFS_LATCH_LOW:
        begin
          sw_clear[7:2] = ~sfr_wdata_in[7:2];
          nest_wr       = 1'b1;
        end
        OFS_LATCH_HIGH:    sw_clear[15:8]  = ~sfr_wdata_in;
        OFS_LATCH_MID_LO:  sw_clear[23:16] = ~sfr_wdata_in;
        OFS_LATCH_MID_HI:  sw_clear[31:24] = ~sfr_wdata_in;
        OFS_LATCH_TOP:     sw_clear[39:32] = ~sfr_wdata_in;
        OFS_ENABLE_LOW:
        begin
          en_wr_mask[7:0] = 8'hFF;
          en_wr_data[7:0] = sfr_wdata_in;
        end
        OFS_ENABLE_HIGH:
        begin
          en_wr_mask[15:8] = 8'hFF;
          en_wr_data[15:8] = sfr_wdata_in;
        end
        OFS_ENABLE_MID_LO:
        begin
          en_wr_mask[23:16] = 8'hFF;
          en_wr_data[23:16] = sfr_wdata_in;
        end
        OFS_ENABLE_MID_HI:
        begin
          en_wr_mask[31:24] = 8'hFF;
          en_wr_data[31:24] = sfr_wdata_in;
        end
        OFS_ENABLE_TOP:
        begin
          en_wr_mask[39:32] = 8'hFF;
          en_wr_data[39:32] = sfr_wdata_in;
        end
        default:
        begin
          sw_clear = '0;
        end
      endcase
    end
    sw_clear = sw_clear & LATCH_IMPL;
  end

  always_comb
  begin
    sfr_hit_out   = 1'b1;
    sfr_rdata_out = 8'h00;
    unique case (sfr_addr_in)
      OFS_LATCH_LOW:     sfr_rdata_out = {request_latch[7:2], nest_level(nest_count)};
      OFS_LATCH_HIGH:    sfr_rdata_out = request_latch[15:8];
      OFS_LATCH_MID_LO:  sfr_rdata_out = request_latch[23:16];
      OFS_LATCH_MID_HI:  sfr_rdata_out = request_latch[31:24];
      OFS_LATCH_TOP:     sfr_rdata_out = request_latch[39:32];
      OFS_ENABLE_LOW:    sfr_rdata_out = {source_enable_flag[7:1], master_enable_flag};
      OFS_ENABLE_HIGH:   sfr_rdata_out = source_enable_flag[15:8];
      OFS_ENABLE_MID_LO: sfr_rdata_out = source_enable_flag[23:16];
      OFS_ENABLE_MID_HI: sfr_rdata_out = source_enable_flag[31:24];
      OFS_ENABLE_TOP:    sfr_rdata_out = source_enable_flag[39:32];
      default:           sfr_hit_out   = 1'b0;
    endcase
    if (!sfr_rd_in)
    begin
      sfr_rdata_out = 8'h00;
    end
  end

  function automatic logic [1:0] nest_level(input logic [NEST_CNT_W-1:0] cnt);
    if (cnt == '0)
      return 2'h0;
    else if (cnt == NEST_CNT_W'(1))
      return 2'h1;
    else if (cnt == NEST_CNT_W'(2))
      return 2'h2;
    else
      return 2'h3;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance arbitration.

  assign eligible = request_latch[NUM_SRC-1:0]
                  & ((source_enable_flag[NUM_SRC-1:0] & {NUM_SRC{master_enable_flag}})
                  | (NUM_SRC'(1) << WDT_SRC));

  irq_priority_pick #(
    .WIDTH     (NUM_SRC)
  ) u_pick (
    .req_in    (eligible),
    .any_out   (pick_any),
    .index_out (pick_idx)
  );

  assign soft_req        = swi_in | undef_in | addr_trap_in;
  assign irq_pending_out = pick_any | soft_req;
  assign start           = (state == ST_IDLE) && instr_done_in && irq_pending_out
                         && clk_en_in;
  assign accept_start_out = start;
  assign accept_busy_out  = (state == ST_ACCEPT);
  assign accept_done_out  = (state == ST_DONE);

  always_comb
  begin
    hw_clear = '0;
    if (start && !soft_req)
    begin
      hw_clear[pick_idx] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request latches.

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      request_latch <= LATCH_RESET;
    end
    else if (clk_en_in)
    begin
      request_latch <= (request_latch & ~(sw_clear | hw_clear)) | raise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable flags and master enable.

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      source_enable_flag <= ENABLE_RESET;
    end
    else if (clk_en_in)
    begin
      source_enable_flag <= ((source_enable_flag & ~en_wr_mask)
                          | (en_wr_data & en_wr_mask)) & ENABLE_IMPL;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_enable_flag <= 1'b0;
      saved_master_out   <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (start)
      begin
        saved_master_out   <= master_enable_flag;
        master_enable_flag <= 1'b0;
      end
      else if (maskable_return_instr_in)
      begin
        master_enable_flag <= 1'b1;
      end
      else if (nonmaskable_return_instr_in)
      begin
        master_enable_flag <= saved_master_in;
      end
      else if (unmask_all_instr_in)
      begin
        master_enable_flag <= 1'b1;
      end
      else if (mask_all_instr_in)
      begin
        master_enable_flag <= 1'b0;
      end
      else if (en_wr_mask[MASTER_BIT])
      begin
        master_enable_flag <= en_wr_data[MASTER_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nesting counter.

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nest_count <= '0;
    end
    else if (clk_en_in)
    begin
      if (start)
      begin
        if (nest_count != '1)
        begin
          nest_count <= nest_count + NEST_CNT_W'(1);
        end
      end
      else if (maskable_return_instr_in || nonmaskable_return_instr_in)
      begin
        nest_count <= nest_count - NEST_CNT_W'(1);
      end
      else if (nest_wr && nest_cmd == NEST_CMD_CLEAR)
      begin
        nest_count <= '0;
      end
      else if (nest_wr && nest_cmd == NEST_CMD_DEC)
      begin
        nest_count <= nest_count - NEST_CNT_W'(1);
      end
    end
  end

  assign nesting_level_field_out = nest_level(nest_count);

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance sequence timing.

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= ST_IDLE;
      acc_count <= '0;
      acc_src   <= '0;
      acc_soft  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            state     <= ST_ACCEPT;
            acc_count <= ACC_CNT_W'(ACCEPT_CYCLES - 2);
            acc_src   <= soft_req ? '0 : pick_idx;
            acc_soft  <= soft_req;
          end
        end
        ST_ACCEPT:
        begin
          if (acc_count == '0)
          begin
            state <= ST_DONE;
          end
          else
          begin
            acc_count <= acc_count - ACC_CNT_W'(1);
          end
        end
        ST_DONE:
        begin
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign accept_src_out = acc_src;

endmodule // irq_latch_ctrl

// ==== test/irq_latch_ctrl_props.sv ====
/*
  Port checker for the latch, enable and nesting block.
  Assumes clk_en_in is high whenever an acceptance or a return is in flight.
*/
`timescale 1ns/100ps
module irq_latch_ctrl_props
  import irq_ctrl_pkg::*;
(
  input wire logic              sys_clk_in,
  input wire logic              nrst_in,
  input wire logic              sfr_wr_in,
  input wire logic              sfr_rd_in,
  input wire logic [ADDR_W-1:0] sfr_addr_in,
  input wire logic [7:0]        sfr_rdata_out,
  input wire logic              sfr_hit_out,
  input wire logic              instr_done_in,
  input wire logic              maskable_return_instr_in,
  input wire logic              irq_pending_out,
  input wire logic              accept_start_out,
  input wire logic              accept_busy_out,
  input wire logic              accept_done_out,
  input wire logic [SRC_W-1:0]  accept_src_out,
  input wire logic [1:0]        nesting_level_field_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////////
  property p_start_cause;
    accept_start_out |-> instr_done_in && irq_pending_out && !accept_busy_out;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without cause");
  property p_busy_len;
    accept_start_out |=> accept_busy_out[*8] ##1 accept_busy_out[*3]
      ##1 (accept_done_out && !accept_busy_out);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("acceptance length wrong");
  property p_done_once;
    accept_done_out |=> !accept_done_out && !accept_busy_out;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done not a pulse");
  property p_src_hold;
    accept_busy_out && $past(accept_busy_out) |-> $stable(accept_src_out);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source changed in service");
  property p_nest_up;
    accept_start_out && nesting_level_field_out == 2'h0 |=> nesting_level_field_out == 2'h1;
  endproperty
  a_nest_up: assert property (p_nest_up) else $error("nesting did not count up");
  property p_nest_ret;
    maskable_return_instr_in && !accept_start_out && !sfr_wr_in
      && nesting_level_field_out == 2'h1 |=> nesting_level_field_out == 2'h0;
  endproperty
  a_nest_ret: assert property (p_nest_ret) else $error("nesting did not count down");
  property p_idle_rd;
    !sfr_rd_in || !sfr_hit_out |-> sfr_rdata_out == 8'h00;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data not zero");
  property p_hit;
    sfr_hit_out == (sfr_addr_in inside {[8'h2A:8'h2F], [8'h3A:8'h3D]});
  endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
endmodule // irq_latch_ctrl_props

bind irq_latch_ctrl irq_latch_ctrl_props irq_latch_ctrl_props_inst (
  .sys_clk_in, .nrst_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_rdata_out,
  .sfr_hit_out, .instr_done_in, .maskable_return_instr_in, .irq_pending_out,
  .accept_start_out, .accept_busy_out, .accept_done_out, .accept_src_out,
  .nesting_level_field_out
);

// ==== test/cpu_stack_model.sv ====
/*
  Stack of saved master enable values, as the core keeps them.
  Assumes one push per acceptance and one pop per non-maskable return.
*/
`timescale 1ns/100ps
module cpu_stack_model
(
  input  wire logic sys_clk_in,
  input  wire logic nrst_in,
  input  wire logic busy_in,
  input  wire logic saved_in,
  input  wire logic pop_in,
  output logic      master_out
);
  logic [7:0] stack;
  logic       busy_q;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stack  <= 8'h00;
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= busy_in;
      if (busy_in && !busy_q)
        stack <= {stack[6:0], saved_in};
      else if (pop_in)
        stack <= {1'b0, stack[7:1]};
    end
  end
  // Outside a pop the value is inverted so a stale sample cannot pass.
  assign master_out = pop_in ? stack[0] : ~stack[0];
endmodule // cpu_stack_model

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the latch, enable and nesting block.
  Assumes the core stack is modelled by cpu_stack_model.
*/
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module tb_top
  import irq_ctrl_pkg::*;
;
  localparam logic [7:0] LA [5] = '{8'h3C, 8'h3D, 8'h2E, 8'h2F, 8'h2B};
  localparam logic [7:0] EA [5] = '{8'h3A, 8'h3B, 8'h2C, 8'h2D, 8'h2A};
  logic               sys_clk;
  logic               nrst;
  logic               clk_en;
  logic [NUM_SRC-1:0] src_req;
  logic [NUM_SRC-1:0] ext_req;
  logic               wr;
  logic               rd;
  logic               done_ev;
  logic [7:0]         addr;
  logic [7:0]         wdata;
  logic [7:0]         rdata;
  logic [3:0]         evs;
  logic [2:0]         nmis;
  logic               hit;
  logic               pend;
  logic               start;
  logic               busy;
  logic               done_o;
  logic               saved;
  logic               popped;
  logic [SRC_W-1:0]   src;
  logic [1:0]         nest;
  int                 errors;
  int                 compares;
  int                 cycles;
  ////////////////////////////////////////////////////////////////////////////////
  irq_latch_ctrl irq_latch_ctrl_inst (
    .sys_clk_in(sys_clk), .nrst_in(nrst), .clk_en_in(clk_en), .src_req_in(src_req),
    .ext_pin_req_in(ext_req), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_addr_in(addr),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
    .instr_done_in(done_ev), .swi_in(nmis[0]), .undef_in(nmis[1]), .addr_trap_in(nmis[2]),
    .unmask_all_instr_in(evs[0]), .mask_all_instr_in(evs[1]),
    .maskable_return_instr_in(evs[2]), .nonmaskable_return_instr_in(evs[3]),
    .saved_master_in(popped), .irq_pending_out(pend), .accept_start_out(start),
    .accept_busy_out(busy), .accept_done_out(done_o), .accept_src_out(src),
    .saved_master_out(saved), .nesting_level_field_out(nest));
  cpu_stack_model cpu_stack_model_inst (
    .sys_clk_in(sys_clk), .nrst_in(nrst), .busy_in(busy), .saved_in(saved),
    .pop_in(evs[3]), .master_out(popped));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d, input logic [NUM_SRC-1:0] r);
    @(posedge sys_clk) #2;
    addr = a;
    wdata = d;
    src_req = r;
    wr = 1'b1;
    @(posedge sys_clk) #2;
    wr = 1'b0;
    src_req = '0;
  endtask
  task automatic rd_b(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) #2;
    addr = a;
    rd = 1'b1;
    @(negedge sys_clk);
    `CHK(rdata, e)
    @(posedge sys_clk) #2;
    rd = 1'b0;
  endtask
  task automatic ev(input logic [3:0] m);
    @(posedge sys_clk) #2;
    evs = m;
    @(posedge sys_clk) #2;
    evs = 4'h0;
  endtask
  task automatic acc(input logic ok, input logic [SRC_W-1:0] s, input logic [2:0] n);
    int w;
    @(posedge sys_clk) #2;
    nmis = n;
    done_ev = 1'b1;
    @(negedge sys_clk);
    `CHK(pend, ok)
    `CHK(start, ok)
    @(posedge sys_clk) #2;
    nmis = 3'h0;
    done_ev = 1'b0;
    if (ok)
    begin
      `CHK(src, s)
      w = 0;
      while (done_o !== 1'b1 && w < 20)
      begin
        @(negedge sys_clk);
        w++;
      end
      `CHK(done_o, 1'b1)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    {nrst, wr, rd, done_ev, evs, nmis, addr, wdata, src_req, ext_req} = '0;
    {errors, compares} = '0;
    clk_en = 1'b1;
    repeat (20) @(posedge sys_clk);
    #2 nrst = 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 5; i++)
    begin
      rd_b(EA[i], 8'h00);
      wr_b(LA[i], 8'hFF, '0);
      rd_b(LA[i], 8'h00);
      wr_b(EA[i], 8'hFF, '0);
      rd_b(EA[i], ENABLE_IMPL[8*i +: 8] | (i == 0 ? 8'h01 : 8'h00));
      wr_b(EA[i], 8'h00, '0);
    end
    rd_b(8'h00, 8'h00);
    `CHK(hit, 1'b0)
    wr_b(8'h00, 8'hFF, '1);
    for (int i = 0; i < 5; i++)
      rd_b(LA[i], LATCH_IMPL[8*i +: 8]);
    wr_b(OFS_LATCH_LOW, 8'hDF, '0);
    rd_b(OFS_LATCH_LOW, 8'h4C);
    wr_b(OFS_LATCH_LOW, 8'hBF, NUM_SRC'(64));
    rd_b(OFS_LATCH_LOW, 8'h4C);
    // Plain loads keep the watchdog and ext0 latches written as 1.
    for (int i = 0; i < 5; i++)
    begin
      wr_b(LA[i], i == 0 ? 8'h0C : 8'h00, '0);
      rd_b(LA[i], i == 0 ? 8'h0C : 8'h00);
    end
    acc(1'b1, 6'd2, 3'h0);
    rd_b(OFS_LATCH_LOW, 8'h09);
    `CHK(saved, 1'b0)
    for (int k = 0; k < 3; k++)
    begin
      acc(1'b1, 6'd0, 3'h1 << k);
      rd_b(OFS_LATCH_LOW, k == 0 ? 8'h0A : 8'h0B);
    end
    wr_b(OFS_LATCH_LOW, 8'hFE, '0);
    rd_b(OFS_LATCH_LOW, 8'h0B);
    wr_b(OFS_LATCH_LOW, 8'hFE, '0);
    rd_b(OFS_LATCH_LOW, 8'h0A);
    wr_b(OFS_LATCH_LOW, 8'hFD, '0);
    rd_b(OFS_LATCH_LOW, 8'h08);
    ev(4'h1);
    rd_b(OFS_ENABLE_LOW, 8'h01);
    ev(4'h2);
    rd_b(OFS_ENABLE_LOW, 8'h00);
    ev(4'h1);
    acc(1'b1, 6'd0, 3'h1);
    `CHK(saved, 1'b1)
    rd_b(OFS_ENABLE_LOW, 8'h00);
    ev(4'h8);
    rd_b(OFS_ENABLE_LOW, 8'h01);
    rd_b(OFS_LATCH_LOW, 8'h08);
    ev(4'h2);
    ev(4'h8);
    rd_b(OFS_ENABLE_LOW, 8'h00);
    wr_b(OFS_LATCH_LOW, 8'hFD, '0);
    @(posedge sys_clk) #2;
    ext_req = NUM_SRC'(32);
    repeat (4) @(posedge sys_clk);
    #2 ext_req = '0;
    rd_b(OFS_LATCH_LOW, 8'h28);
    wr_b(OFS_ENABLE_LOW, 8'h28, '0);
    acc(1'b0, 6'd0, 3'h0);
    ev(4'h1);
    acc(1'b1, 6'd3, 3'h0);
    rd_b(OFS_ENABLE_LOW, 8'h28);
    ev(4'h4);
    acc(1'b1, 6'd5, 3'h0);
    rd_b(OFS_LATCH_LOW, 8'h01);
    // With the clock enable low, writes and requests leave all state frozen.
    @(posedge sys_clk) #2;
    clk_en = 1'b0;
    wr_b(OFS_ENABLE_LOW, 8'hFF, '1);
    rd_b(OFS_ENABLE_LOW, 8'h28);
    rd_b(OFS_LATCH_LOW, 8'h01);
    clk_en = 1'b1;
    test_done();
  end
endmodule // tb_top
